// >>> adrc_dram_ctrl.sv
// host-side controller driving a 4M x 1 asynchronous DRAM by its strobes
`timescale 1ns/10ps
// Notes on behaviour
// - after power wait 100 us, then issue eight row-strobe cycles before use.
// - finish start-up with one refresh cycle holding write strobe high.
// - column-before-row refresh with write strobe low enters test mode; keep it high.
// - refresh all 1024 rows within every 16 ms.
// - never drop write strobe between the early-write and read-write windows.
// - hold write strobe high after row or column strobe rise to end reads.
// - row strobe low at most 10,000 ns single, 125,000 ns in page bursts.
module adrc_dram_ctrl #(
  parameter int POWERUP_CYC    = adrc_pkg::POWERUP_CYC_DEF,
  parameter int PAGE_LIMIT_CYC = adrc_pkg::PAGE_LIMIT_CYC_DEF
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_i,
  input  wire logic                                    req_valid_i,
  output logic                                         req_ready_o,
  input  wire logic                                    req_write_i,
  input  wire logic                                    req_rmw_i,
  input  wire logic [adrc_pkg::ROW_W+adrc_pkg::COL_W-1:0] req_addr_i,
  input  wire logic                                    req_wdata_i,
  output logic                                         rdata_o,
  output logic                                         rdata_valid_o,
  output logic                                         init_done_o,
  output logic                                         dram_ras_n_o,
  output logic                                         dram_cas_n_o,
  output logic                                         dram_we_n_o,
  output logic [adrc_pkg::ROW_W-1:0]                   dram_addr_o,
  output logic                                         dram_din_o,
  input  wire logic                                    dram_dout_i
);
  import adrc_pkg::*;

  localparam int REF_AGE_MAX = REF_INT_CYC + 64;

  adrc_state_t       state_reg;
  adrc_state_t       state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [WIDE_W-1:0] pwr_cnt_reg;
  logic [WIDE_W-1:0] ras_cnt_reg;
  logic [WIDE_W-1:0] ref_age_reg;
  logic [3:0]        init_cnt_reg;
  logic [ROW_W-1:0]  cur_row_reg;
  logic [COL_W-1:0]  cur_col_reg;
  logic              cur_wr_reg;
  logic              cur_rmw_reg;
  logic              dout_s1_reg;
  logic              dout_s2_reg;
  logic              pwr_done;
  logic              init_done;
  logic              ref_pend;
  logic              ref_ack;
  logic              acc_end;
  logic              page_ok;
  logic              idle_take;
  logic              page_take;
  logic              req_fire;

  function automatic logic [ROW_W-1:0] row_of(input logic [ROW_W+COL_W-1:0] a);
    row_of = a[ROW_W+COL_W-1:COL_W];
  endfunction : row_of

  function automatic logic [COL_W-1:0] col_of(input logic [ROW_W+COL_W-1:0] a);
    col_of = a[COL_W-1:0];
  endfunction : col_of

  function automatic logic [CNT_W-1:0] len_m1(input int d);
    len_m1 = CNT_W'(d - 1);
  endfunction : len_m1

  assign pwr_done    = (pwr_cnt_reg == WIDE_W'(POWERUP_CYC));
  assign init_done   = (init_cnt_reg == INIT_TOTAL);
  assign init_done_o = init_done;
  assign acc_end     = (cnt_reg == '0) &&
                       (((state_reg == ST_COL) && !cur_rmw_reg) || (state_reg == ST_WRWE));
  // leave room for the longest access and precharge before the page limit
  assign page_ok     = (ras_cnt_reg < WIDE_W'(PAGE_LIMIT_CYC - PAGE_GUARD_CYC));
  assign idle_take   = (state_reg == ST_IDLE) && init_done && !ref_pend;
  // a pending refresh closes the page so its wait stays short
  assign page_take   = acc_end && !ref_pend && page_ok &&
                       (row_of(req_addr_i) == cur_row_reg);
  assign req_ready_o = idle_take || page_take;
  assign req_fire    = req_ready_o && req_valid_i;
  assign ref_ack     = (state_reg == ST_CBR_CAS) && (cnt_reg == '0);

  adrc_refresh_timer #(
    .INTERVAL (REF_INT_CYC)
  ) u_refresh (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (init_done),
    .ack_i     (ref_ack),
    .pending_o (ref_pend)
  );

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    case (state_reg)
      ST_POWER:
        if (pwr_done)
        begin
          state_next = ST_IDLE;
        end
      ST_IDLE:
        if (!init_done || ref_pend)
        begin
          state_next = ST_CBR_CAS;
          cnt_next   = len_m1(T_CSR_CYC);
        end
        else if (req_valid_i)
        begin
          state_next = ST_ROW;
          cnt_next   = len_m1(RCD_CYC);
        end
      ST_ROW, ST_CP:
        if (cnt_reg == '0)
        begin
          state_next = ST_COL;
          cnt_next   = cur_wr_reg ? len_m1(WR_CAS_CYC) : len_m1(RD_WAIT_CYC);
        end
      ST_COL, ST_WRWE:
        if (cnt_reg == '0)
        begin
          if ((state_reg == ST_COL) && cur_rmw_reg)
          begin
            state_next = ST_WRWE;
            cnt_next   = len_m1(WRWE_CYC);
          end
          else if (page_take && req_valid_i)
          begin
            state_next = ST_CP;
            cnt_next   = len_m1(T_CP_CYC);
          end
          else
          begin
            state_next = ST_PRE;
            cnt_next   = len_m1(T_RP_CYC);
          end
        end
      ST_PRE:
        if (cnt_reg == '0)
        begin
          state_next = ST_IDLE;
        end
      ST_CBR_CAS:
        if (cnt_reg == '0)
        begin
          state_next = ST_CBR_RAS;
          cnt_next   = len_m1(T_RAS_CYC);
        end
      ST_CBR_RAS:
        if (cnt_reg == '0)
        begin
          state_next = ST_PRE;
          cnt_next   = len_m1(T_RP_CYC);
        end
      default:
      begin
        state_next = ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_POWER;
      cnt_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pwr_cnt_reg <= '0;
    else if (!pwr_done)
      pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      init_cnt_reg <= '0;
    else if (ref_ack && !init_done)
      init_cnt_reg <= init_cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ras_cnt_reg <= '0;
    else if (dram_ras_n_o)
      ras_cnt_reg <= '0;
    else
      ras_cnt_reg <= ras_cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ref_age_reg <= '0;
    else if (ref_ack)
      ref_age_reg <= '0;
    else if (init_done && (ref_age_reg != '1))
      ref_age_reg <= ref_age_reg + 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cur_row_reg <= '0;
      cur_col_reg <= '0;
      cur_wr_reg  <= 1'b0;
      cur_rmw_reg <= 1'b0;
      dram_din_o  <= 1'b0;
    end
    else if (req_fire)
    begin
      cur_row_reg <= row_of(req_addr_i);
      cur_col_reg <= col_of(req_addr_i);
      cur_wr_reg  <= req_write_i && !req_rmw_i;
      cur_rmw_reg <= req_rmw_i;
      dram_din_o  <= req_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      dram_addr_o <= '0;
    else if (req_fire && (state_reg == ST_IDLE))
      dram_addr_o <= row_of(req_addr_i);
    else if (req_fire)
      dram_addr_o <= col_of(req_addr_i);
    else if ((state_reg == ST_ROW) && (state_next == ST_COL))
      dram_addr_o <= cur_col_reg;
  end

  // write strobe only falls with column strobe or after the read sample
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dram_ras_n_o <= 1'b1;
      dram_cas_n_o <= 1'b1;
      dram_we_n_o  <= 1'b1;
    end
    else
    begin
      dram_ras_n_o <= !(state_next inside {ST_ROW, ST_COL, ST_WRWE, ST_CP, ST_CBR_RAS});
      dram_cas_n_o <= !(state_next inside {ST_COL, ST_WRWE, ST_CBR_CAS, ST_CBR_RAS});
      dram_we_n_o  <= !((state_next == ST_WRWE) ||
                        ((state_next == ST_COL) && cur_wr_reg));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dout_s1_reg <= 1'b0;
      dout_s2_reg <= 1'b0;
    end
    else
    begin
      dout_s1_reg <= dram_dout_i;
      dout_s2_reg <= dout_s1_reg;
    end
  end

  // sampled late in the column-strobe-low window while the output is held
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o       <= 1'b0;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      rdata_valid_o <= (state_reg == ST_COL) && (cnt_reg == '0) && !cur_wr_reg;
      if ((state_reg == ST_COL) && (cnt_reg == '0) && !cur_wr_reg)
        rdata_o <= dout_s2_reg;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cbr_fall;
    dram_ras_n_o && !dram_cas_n_o ##1 !dram_ras_n_o;
  endsequence

  sequence s_row_open;
    $fell(dram_ras_n_o) && dram_cas_n_o;
  endsequence

  sequence s_rmw_start;
    $fell(dram_cas_n_o) && !dram_ras_n_o && cur_rmw_reg;
  endsequence

  a_power_wait: assert property (!pwr_done |-> dram_ras_n_o)
    else $error("row strobe before power-up wait ended");
  a_init_first: assert property ((state_reg == ST_ROW) |-> (init_cnt_reg == 4'h9))
    else $error("access before start-up refreshes done");
  a_cbr_we_high: assert property ((dram_ras_n_o && !dram_cas_n_o) |-> dram_we_n_o)
    else $error("refresh entry with write strobe low");
  a_cbr_hold: assert property (s_cbr_fall |->
      (!dram_ras_n_o && !dram_cas_n_o)[*4] ##1 (dram_ras_n_o && dram_cas_n_o))
    else $error("refresh cycle shape wrong");
  a_ref_age: assert property (ref_age_reg < REF_AGE_MAX)
    else $error("refresh interval overrun");
  a_ras_limit: assert property (ras_cnt_reg < PAGE_LIMIT_CYC)
    else $error("row strobe low too long");
  a_row_to_col: assert property (s_row_open |->
      dram_cas_n_o[*2] ##1 !dram_cas_n_o)
    else $error("row to column delay wrong");
  a_row_addr: assert property (s_row_open |-> (dram_addr_o == cur_row_reg))
    else $error("row address not on pins at row strobe fall");
  a_early_write: assert property (($fell(dram_cas_n_o) && !dram_ras_n_o && cur_wr_reg) |->
      !dram_we_n_o)
    else $error("early write without write strobe low");
  a_rmw_seq: assert property (s_rmw_start |->
      (dram_we_n_o && !dram_cas_n_o)[*5] ##1 (!dram_we_n_o && rdata_valid_o))
    else $error("read-modify-write order wrong");
  a_we_window: assert property ($fell(dram_we_n_o) |->
      ($fell(dram_cas_n_o) || (state_reg == ST_WRWE)))
    else $error("write strobe fell between windows");
  a_read_hold: assert property (($rose(dram_cas_n_o) && !$past(dram_we_n_o, 1)) == 1'b0 ||
      $past(cur_wr_reg, 1) || $past(cur_rmw_reg, 1))
    else $error("write strobe low at end of read");
  a_read_in_cas: assert property (rdata_valid_o |-> !$past(dram_cas_n_o, 1))
    else $error("read sample outside column strobe low");
  a_page_cycle: assert property (($fell(dram_cas_n_o) && !dram_ras_n_o) |=>
      (!$fell(dram_cas_n_o))[*2])
    else $error("page cycle too short");

endmodule : adrc_dram_ctrl

// >>> adrc_pkg.sv
// constants, timing counts and state encoding for the 4M x 1 DRAM controller
package adrc_pkg;

  localparam int CLK_NS = 20;

  // least times round up to whole cycles, longest times round down
  function automatic int cyc_min(input int ns);
    cyc_min = (ns + CLK_NS - 1) / CLK_NS;
    if (cyc_min < 1)
    begin
      cyc_min = 1;
    end
  endfunction : cyc_min

  function automatic int cyc_max(input int ns);
    cyc_max = ns / CLK_NS;
    if (cyc_max < 1)
    begin
      cyc_max = 1;
    end
  endfunction : cyc_max

  localparam int ROW_W = 11;
  localparam int COL_W = 11;
  localparam int CNT_W = 4;
  localparam int WIDE_W = 16;

  localparam int POWERUP_US          = 100;
  localparam int POWERUP_CYC_DEF     = cyc_min(POWERUP_US * 1000);
  localparam int INIT_RAS_CYCLES     = 8;
  localparam logic [3:0] INIT_TOTAL  = 4'(INIT_RAS_CYCLES + 1);

  localparam int REF_ROWS            = 1024;
  localparam int REF_MS              = 16;
  localparam int REF_INT_CYC         = cyc_max(REF_MS * 1000000 / REF_ROWS);

  localparam int PAGE_ROW_LOW_LIMIT_NS = 125000;
  localparam int PAGE_LIMIT_CYC_DEF    = cyc_max(PAGE_ROW_LOW_LIMIT_NS);
  localparam int PAGE_CYCLE_TIME_NS    = 50;
  localparam int PAGE_CYCLE_TIME_CYC   = cyc_min(PAGE_CYCLE_TIME_NS);

  localparam int T_RP_NS  = 70;
  localparam int T_RAS_NS = 80;
  localparam int T_CSR_NS = 10;
  localparam int T_CP_NS  = 10;
  localparam int T_WP_NS  = 15;
  localparam int T_RWL_NS = 20;
  localparam int ROW_TO_COL_DELAY_NS = 25;
  localparam int ROW_ACCESS_TIME_NS  = 80;
  localparam int COL_ACCESS_TIME_NS  = 20;
  localparam int COLADDR_ACCESS_TIME_NS = 40;
  localparam int SYNC_STAGES = 2;

  localparam int T_RP_CYC   = cyc_min(T_RP_NS);
  localparam int T_RAS_CYC  = cyc_min(T_RAS_NS);
  localparam int T_CSR_CYC  = cyc_min(T_CSR_NS);
  localparam int T_CP_CYC   = cyc_min(T_CP_NS);
  localparam int RCD_CYC    = cyc_min(ROW_TO_COL_DELAY_NS);
  localparam int RAC_LEFT   = cyc_min(ROW_ACCESS_TIME_NS) - RCD_CYC;
  localparam int CAC_CYC    = cyc_min(COL_ACCESS_TIME_NS);
  localparam int AA_CYC     = cyc_min(COLADDR_ACCESS_TIME_NS);
  localparam int ACC_CYC    = (RAC_LEFT > AA_CYC) ? RAC_LEFT
                                                  : ((AA_CYC > CAC_CYC) ? AA_CYC : CAC_CYC);
  // one spare cycle so the synchronised sample sits past the access edge
  localparam int RD_WAIT_CYC = ACC_CYC + SYNC_STAGES + 1;
  localparam int WR_CAS_CYC  = (T_RAS_CYC > RCD_CYC) ? T_RAS_CYC - RCD_CYC : 1;
  localparam int WRWE_CYC    = (cyc_min(T_RWL_NS) > cyc_min(T_WP_NS)) ? cyc_min(T_RWL_NS)
                                                                     : cyc_min(T_WP_NS);
  localparam int PAGE_GUARD_CYC = RD_WAIT_CYC + WRWE_CYC + T_CP_CYC + T_RP_CYC;

  typedef enum logic [8:0] {
    ST_POWER   = 9'h001,
    ST_IDLE    = 9'h002,
    ST_ROW     = 9'h004,
    ST_COL     = 9'h008,
    ST_WRWE    = 9'h010,
    ST_CP      = 9'h020,
    ST_PRE     = 9'h040,
    ST_CBR_CAS = 9'h080,
    ST_CBR_RAS = 9'h100
  } adrc_state_t;

endpackage : adrc_pkg

// >>> adrc_refresh_timer.sv
// periodic refresh request with sticky pending flag
`timescale 1ns/10ps
module adrc_refresh_timer #(
  parameter int INTERVAL = adrc_pkg::REF_INT_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic ack_i,
  output logic      pending_o
);
  import adrc_pkg::*;

  logic [WIDE_W-1:0] tick_cnt_reg;
  logic              tick;

  assign tick = enable_i && (tick_cnt_reg == WIDE_W'(INTERVAL - 1));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tick_cnt_reg <= '0;
    else if (!enable_i || tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  // a tick landing on the acknowledge cycle keeps the flag set
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pending_o <= 1'b0;
    else if (tick)
      pending_o <= 1'b1;
    else if (ack_i)
      pending_o <= 1'b0;
  end

endmodule : adrc_refresh_timer

// >>> adrc_dram_model.sv
// behavioural 4M x 1 DRAM answering the controller's strobes
`timescale 1ns/10ps
module adrc_dram_model #(
  parameter int LIMIT_NS = 125000
) (
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [10:0] addr_i,
  input  wire logic        din_i,
  input  wire logic        slow_i,
  output logic             dout_o,
  output int               ras_o,
  output int               cbr_o,
  output int               viol_o,
  output time              first_o
);
  logic        mem [logic [21:0]];
  logic [10:0] row_reg;
  logic [10:0] col_reg;
  logic [9:0]  ref_reg;
  logic        rd_reg;
  logic        late_reg;
  time         ras_t;
  time         cas_t;

  initial
  begin
    dout_o = 1'h0;
    ras_o = 0;
    cbr_o = 0;
    viol_o = 0;
    first_o = 0;
    ref_reg = 10'h000;
    rd_reg = 1'h0;
    late_reg = 1'h0;
    ras_t = 0;
    cas_t = 0;
  end

  // row address moves on the same edge as the strobe, so let it settle first
  always @(negedge ras_n_i)
  begin
    #1;
    ras_t = $time;
    cas_t = 0;
    first_o = (ras_o == 0) ? $time : first_o;
    ras_o++;
    if (!cas_n_i)
    begin
      ref_reg = ref_reg + 10'h001;
      cbr_o++;
      viol_o += (we_n_i ? 0 : 1);
    end
    else
    begin
      row_reg = addr_i;
    end
  end

  always @(posedge ras_n_i)
  begin
    if ($time - ras_t > LIMIT_NS)
      viol_o++;
  end

  // sampled 1 ns late so strobes moving on one edge have all settled
  always @(negedge cas_n_i)
  begin
    #1;
    if (!ras_n_i)
    begin
      if (cas_t != 0 && $time - cas_t < 50)
        viol_o++;
      cas_t = $time;
      col_reg = addr_i;
      rd_reg = we_n_i;
      late_reg = 1'h0;
      if (!we_n_i)
        mem[{row_reg, col_reg}] = din_i;
      else
      begin
        #(slow_i ? 40 : 20);
        if (!cas_n_i)
          dout_o = mem.exists({row_reg, col_reg}) ? mem[{row_reg, col_reg}] : 1'h0;
      end
    end
  end

  always @(negedge we_n_i)
  begin
    #2;
    if (!ras_n_i && !cas_n_i && rd_reg)
    begin
      if ($time - cas_t < 20 || $time - ras_t < 80)
        viol_o++;
      late_reg = 1'h1;
      mem[{row_reg, col_reg}] = din_i;
    end
  end

  // a released output shows the inverse, never a stale copy of the bit
  always @(posedge cas_n_i)
  begin
    if (rd_reg && !late_reg && !we_n_i)
      viol_o++;
    dout_o = ~dout_o;
  end
endmodule : adrc_dram_model

// >>> adrc_dram_ctrl_test.sv
// self-checking bench for the DRAM controller against a behavioural memory
`timescale 1ns/10ps
module adrc_dram_ctrl_test;
  import adrc_pkg::*;
  localparam int PW = 20;
  localparam int PL = 40;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        req_valid_i = 1'h0;
  logic        req_ready_o;
  logic        req_write_i = 1'h0;
  logic        req_rmw_i = 1'h0;
  logic [21:0] req_addr_i = 22'h000000;
  logic        req_wdata_i = 1'h0;
  logic        rdata_o;
  logic        rdata_valid_o;
  logic        init_done_o;
  logic        dram_ras_n_o;
  logic        dram_cas_n_o;
  logic        dram_we_n_o;
  logic [10:0] dram_addr_o;
  logic        dram_din_o;
  logic        dram_dout_i;
  logic        slow = 1'h0;
  int          ras_cnt;
  int          cbr_cnt;
  int          viol_cnt;
  time         first_t;
  time         rel_t;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h00017B93;
  logic        exp_q [$];
  logic        shadow [logic [21:0]];
  logic [21:0] addr_list [8];

  always #10 clk_i = ~clk_i;

  adrc_dram_ctrl #(.POWERUP_CYC(PW), .PAGE_LIMIT_CYC(PL)) uut (
    .clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_write_i, .req_rmw_i, .req_addr_i,
    .req_wdata_i, .rdata_o, .rdata_valid_o, .init_done_o, .dram_ras_n_o, .dram_cas_n_o,
    .dram_we_n_o, .dram_addr_o, .dram_din_o, .dram_dout_i);

  adrc_dram_model #(.LIMIT_NS(PL * CLK_NS)) mdl (
    .ras_n_i(dram_ras_n_o), .cas_n_i(dram_cas_n_o), .we_n_i(dram_we_n_o),
    .addr_i(dram_addr_o), .din_i(dram_din_o), .slow_i(slow), .dout_o(dram_dout_i),
    .ras_o(ras_cnt), .cbr_o(cbr_cnt), .viol_o(viol_cnt), .first_o(first_t));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  task automatic compare_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : compare_bit

  task automatic compare_int(input string what, input int exp, input int got);
    samples_checked++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : compare_int

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  // the request stays up after the take edge so a same-row follower pages on
  task automatic issue(input logic wr, input logic rmw, input logic [21:0] a, input logic d);
    int n;
    n = 0;
    @(negedge clk_i);
    req_valid_i = 1'h1;
    req_write_i = wr;
    req_rmw_i = rmw;
    req_addr_i = a;
    req_wdata_i = d;
    #1;
    while (req_ready_o !== 1'h1 && n < 3000)
    begin
      @(negedge clk_i);
      #1;
      n++;
    end
    if (!wr || rmw)
      exp_q.push_back(shadow.exists(a) ? shadow[a] : 1'h0);
    if (wr || rmw)
      shadow[a] = d;
    @(posedge clk_i);
  endtask : issue

  task automatic idle(input int c);
    @(negedge clk_i);
    req_valid_i = 1'h0;
    repeat (c) @(posedge clk_i);
  endtask : idle

  task automatic do_reset();
    @(negedge clk_i);
    rst_i = 1'h1;
    req_valid_i = 1'h0;
    repeat (2) @(negedge clk_i);
    compare_bit("ready in reset", 1'h0, req_ready_o);
    compare_bit("row strobe in reset", 1'h1, dram_ras_n_o);
    compare_bit("start-up flag in reset", 1'h0, init_done_o);
    exp_q.delete();
    rst_i = 1'h0;
    rel_t = $time;
  endtask : do_reset

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done_o !== 1'h1 && n < 500)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_init

  task automatic wait_cbr(output int gap);
    int c;
    c = cbr_cnt;
    gap = 0;
    while (cbr_cnt == c && gap < 1000)
    begin
      @(posedge clk_i);
      gap++;
    end
  endtask : wait_cbr

  // looked at mid-cycle, while the registered answer stands
  always @(negedge clk_i)
  begin
    if (rdata_valid_o === 1'h1)
    begin
      if (exp_q.size() == 0)
        compare_bit("unexpected read answer", 1'h0, 1'h1);
      else
        compare_bit("read data", exp_q.pop_front(), rdata_o);
    end
  end

  initial
  begin
    #(20000 * CLK_NS);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    int gap;
    int r0;
    int c0;
    do_reset();
    wait_init();
    compare_bit("start-up done", 1'h1, init_done_o);
    compare_int("start-up refreshes", 9, cbr_cnt);
    compare_int("power wait kept", 1, int'(first_t - rel_t >= PW * CLK_NS));
    end_test("start-up");
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      addr_list[i] = seed[21:0];
      issue(1'h1, 1'h0, seed[21:0], seed[31]);
    end
    for (int i = 0; i < 8; i++)
      issue(1'h0, 1'h0, addr_list[i], 1'h0);
    idle(20);
    end_test("write and read");
    wait_cbr(gap);
    wait_cbr(gap);
    compare_int("refresh spacing ok", 1, int'(gap <= REF_INT_CYC + 64));
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      addr_list[i] = {addr_list[0][21:11], seed[10:0]};
      issue(1'h1, 1'h0, addr_list[i], seed[31]);
    end
    r0 = ras_cnt;
    for (int i = 0; i < 8; i++)
      issue(1'h0, 1'h0, addr_list[i], 1'h0);
    idle(20);
    compare_int("row opens in long burst", 1, int'((ras_cnt - r0) inside {[2:3]}));
    end_test("page burst");
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      issue(seed[0], 1'h1, addr_list[i], seed[31]);
      issue(1'h0, 1'h0, addr_list[i], 1'h0);
    end
    idle(20);
    end_test("read-modify-write");
    slow = 1'h1;
    for (int i = 0; i < 8; i++)
      issue(1'h0, 1'h0, addr_list[i], 1'h0);
    idle(20);
    slow = 1'h0;
    end_test("slow memory");
    issue(1'h0, 1'h0, addr_list[0], 1'h0);
    idle(2);
    do_reset();
    c0 = cbr_cnt;
    wait_init();
    compare_bit("start-up done again", 1'h1, init_done_o);
    compare_int("start-up refreshes again", 9, cbr_cnt - c0);
    issue(1'h0, 1'h0, addr_list[1], 1'h0);
    idle(20);
    end_test("reset in mid-run");
    compare_int("protocol faults seen", 0, viol_cnt);
    compare_int("answers outstanding", 0, exp_q.size());
    wrap_up();
  end
endmodule : adrc_dram_ctrl_test
